// ==== core/rmx_pkg.sv ====
// Constants, register map and types of the strap pin multiplexer.
// Assumes a 32-bit classic Wishbone register bus and one 100 MHz clock.
package rmx_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] RMX_OFF_MODE  = 8'h00;
  localparam logic [7:0] RMX_OFF_FDIR  = 8'h04;
  localparam logic [7:0] RMX_OFF_FOUT  = 8'h08;
  localparam logic [7:0] RMX_OFF_FIN   = 8'h0C;
  localparam logic [7:0] RMX_OFF_CTRL  = 8'h10;
  localparam logic [7:0] RMX_OFF_ISTAT = 8'h14;
  localparam logic [7:0] RMX_OFF_INTERRUPT_MASK = 8'h18;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int RMX_STRAP_C   = 2;
  localparam int RMX_STRAP_D   = 3;
  localparam int RMX_CTL_SPALT = 0;
  localparam int RMX_CTL_GO    = 1;
  localparam int RMX_CTL_ELEDG = 2;
  localparam int RMX_CTL_SA0ED = 3;
  localparam int RMX_CTL_SA1ED = 4;
  localparam int RMX_CTL_FO    = 5;
  localparam int RMX_IRQ_EL    = 0;
  localparam int RMX_IRQ_L0    = 1;
  localparam int RMX_IRQ_L1    = 2;
  localparam int RMX_IRQ_E     = 3;
  localparam int RMX_IRQ_SA0   = 4;
  localparam int RMX_IRQ_SA1   = 5;
  localparam int RMX_NIRQ      = 6;
  localparam int RMX_NCTL      = 6;
  localparam int RMX_NFLAG     = 8;
  localparam int RMX_AW        = 14;
  localparam int RMX_DW        = 24;
  localparam int RMX_HW        = 16;
  localparam int RMX_NSYNC     = 50;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RMX_FDIR_RST  = 8'h00;
  localparam logic [7:0] RMX_FOUT_RST  = 8'hFF;
  localparam logic [5:0] RMX_CTRL_RST  = 6'h00;
  localparam logic [5:0] RMX_INTERRUPT_MASK_RST = 6'h00;
  localparam logic [3:0] RMX_STRAP_RST = 4'h0;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RMX_SP_PM   = 2'b00,
    RMX_SP_DM   = 2'b01,
    RMX_SP_BYTE = 2'b10,
    RMX_SP_IO   = 2'b11
  } rmx_space_t;

  typedef enum logic {
    RMX_BUS_OWN   = 1'b0,
    RMX_BUS_GRANT = 1'b1
  } rmx_bus_st_t;

endpackage

// ==== core/rmx_sync.sv ====
// Two-flop synchroniser for a vector of pin levels.
// Assumes each bit is an independent level; words are not kept coherent.
`timescale 1ns/1ns
module rmx_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // No reset: straps are settled while reset is held.
  always_ff @(posedge clk) begin
    meta_q <= din;
    dout   <= meta_q;
  end

endmodule

// ==== core/rmx_pin_mux.sv ====
// Reset-time mode straps and pin multiplexing for the processor pins.
// Assumes clk at 100 MHz, synchronous active-low rst_b, pins resolved
// outside from each out/oe pair, and a Wishbone register master.
//
// Functional notes
// - Strap pins select mode only during reset.
// - Mode-C strap picks full memory or host.
// - Full mode: 14 address, 24 data pins.
// - Full mode: byte accesses put address on top data byte.
// - Host mode: 16-pin multiplexed host address/data bus.
// - Host mode: one address pin, upper data only.
// - Host controls in; open-source ack, strap D configures.
// - Interrupt/flag pins keep both functions together.
// - Masked-on pin interrupt fires, driven or flagged.
// - Edge-or-level, two level-only, one edge-only.
// - Serial port pins or interrupts plus flags.
// - Bus pins fixed at reset; serial live.
// - Bus grant halts, except go mode continues.
//
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
module rmx_pin_mux
  import rmx_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic [7:0]           wb_adr,
  input  wire logic [31:0]          wb_wdat,
  input  wire logic [3:0]           wb_sel,
  input  wire logic                 wb_we,
  input  wire logic                 wb_cyc,
  input  wire logic                 wb_stb,
  output logic      [31:0]          wb_rdat,
  output logic                      wb_ack,
  output logic                      irq_out,
  output logic      [RMX_NIRQ-1:0]  irq_vector,
  input  wire logic [RMX_NFLAG-1:0] prog_flag_in,
  output logic      [RMX_NFLAG-1:0] prog_flag_out,
  output logic      [RMX_NFLAG-1:0] prog_flag_oe,
  input  wire logic [RMX_AW-1:0]    a_pin_in,
  output logic      [RMX_AW-1:0]    a_pin_out,
  output logic      [RMX_AW-1:0]    a_pin_oe,
  input  wire logic [RMX_DW-1:0]    d_pin_in,
  output logic      [RMX_DW-1:0]    d_pin_out,
  output logic      [RMX_DW-1:0]    d_pin_oe,
  output logic      [4:0]           mem_sel_b,
  output logic                      mem_rd_b,
  output logic                      mem_wr_b,
  output logic                      mem_ctl_oe,
  input  wire logic                 bus_request_in_b,
  output logic                      bus_grant_out_b,
  output logic                      bus_grant_hung_out_b,
  input  wire logic                 mem_req,
  input  wire logic                 mem_we,
  input  wire logic [1:0]           mem_space,
  input  wire logic [RMX_AW-1:0]    mem_addr,
  input  wire logic [RMX_DW-1:0]    mem_wdata,
  input  wire logic [7:0]           byte_addr_hi,
  output logic      [RMX_DW-1:0]    mem_rdata,
  output logic                      core_halt,
  output logic                      host_mode,
  input  wire logic [RMX_HW-1:0]    host_ad_out,
  input  wire logic                 host_ad_drive,
  input  wire logic                 host_ack_ready,
  input  wire logic                 host_ack_done,
  output logic      [RMX_HW-1:0]    host_ad_in,
  output logic                      host_write_enable_b,
  output logic                      host_read_enable_b,
  output logic                      host_address_latch,
  output logic                      host_port_select_b,
  input  wire logic                 sp_rfs_in,
  output logic                      sp_rfs_out,
  output logic                      sp_rfs_oe,
  input  wire logic                 sp_tfs_in,
  output logic                      sp_tfs_out,
  output logic                      sp_tfs_oe,
  input  wire logic                 sp_dr_in,
  output logic                      sp_dt_out,
  output logic                      sp_dt_oe,
  input  wire logic                 sport_rfs_out,
  input  wire logic                 sport_rfs_oe,
  input  wire logic                 sport_tfs_out,
  input  wire logic                 sport_tfs_oe,
  input  wire logic                 sport_dt_out,
  input  wire logic                 sport_dt_oe,
  output logic                      sport_rfs_in,
  output logic                      sport_tfs_in,
  output logic                      sport_dr_in
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [RMX_NSYNC-1:0] pin_s;
  logic [RMX_NFLAG-1:0] flag_s;
  logic [RMX_AW-1:0]    a_s;
  logic [RMX_DW-1:0]    d_s;
  logic                 rfs_s;
  logic                 tfs_s;
  logic                 dr_s;
  logic                 breq_b_s;
  rmx_sync #(.W(RMX_NSYNC)) u_sync (
    .clk  (clk),
    .din  ({bus_request_in_b, sp_dr_in, sp_tfs_in, sp_rfs_in,
            d_pin_in, a_pin_in, prog_flag_in}),
    .dout (pin_s)
  );
  assign {breq_b_s, dr_s, tfs_s, rfs_s, d_s, a_s, flag_s} = pin_s;

  // ----------------------------------------------------------------------
  // Strap capture and mode
  // ----------------------------------------------------------------------
  logic [3:0] strap_q;
  logic       ack_cfg;
  // Straps track the pins in reset, then freeze so flags cannot move the mode.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      strap_q <= flag_s[3:0];
    end
  end
  assign host_mode = strap_q[RMX_STRAP_C];
  assign ack_cfg   = strap_q[RMX_STRAP_D];

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction
  logic                 ack_q;
  logic [31:0]          rdat_q;
  logic [31:0]          rd_data;
  logic                 wr_en;
  logic                 acc;
  logic [RMX_NFLAG-1:0] fdir_q;
  logic [RMX_NFLAG-1:0] fout_q;
  logic [RMX_NCTL-1:0]  ctrl_q;
  logic [RMX_NIRQ-1:0]  stat_q;
  logic [RMX_NIRQ-1:0]  stat_d;
  logic [RMX_NIRQ-1:0]  mask_q;
  logic [RMX_NIRQ-1:0]  ev;
  logic [RMX_NIRQ-1:0]  w1c;
  assign acc   = wb_cyc && wb_stb && !ack_q;
  assign wr_en = acc && wb_we && wb_sel[0];
  assign w1c   = (wr_en && hit(wb_adr, RMX_OFF_ISTAT)) ?
                 wb_wdat[RMX_NIRQ-1:0] : '0;
  assign rd_data =
    hit(wb_adr, RMX_OFF_MODE)  ? 32'({host_mode, strap_q}) :
    hit(wb_adr, RMX_OFF_FDIR)  ? 32'(fdir_q) :
    hit(wb_adr, RMX_OFF_FOUT)  ? 32'(fout_q) :
    hit(wb_adr, RMX_OFF_FIN)   ? 32'({dr_s, flag_s}) :
    hit(wb_adr, RMX_OFF_CTRL)  ? 32'(ctrl_q) :
    hit(wb_adr, RMX_OFF_ISTAT) ? 32'(stat_q) :
    hit(wb_adr, RMX_OFF_INTERRUPT_MASK) ? 32'(mask_q) : '0;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_q  <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q  <= acc;
      rdat_q <= acc ? rd_data : rdat_q;
    end
  end

  // Serial pin function may change at any time.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fdir_q <= RMX_FDIR_RST;
      fout_q <= RMX_FOUT_RST;
      ctrl_q <= RMX_CTRL_RST;
      mask_q <= RMX_INTERRUPT_MASK_RST;
    end else if (wr_en) begin
      if (hit(wb_adr, RMX_OFF_FDIR))  fdir_q <= wb_wdat[RMX_NFLAG-1:0];
      if (hit(wb_adr, RMX_OFF_FOUT))  fout_q <= wb_wdat[RMX_NFLAG-1:0];
      if (hit(wb_adr, RMX_OFF_CTRL))  ctrl_q <= wb_wdat[RMX_NCTL-1:0];
      if (hit(wb_adr, RMX_OFF_INTERRUPT_MASK)) mask_q <= wb_wdat[RMX_NIRQ-1:0];
    end
  end
  assign wb_ack  = ack_q;
  assign wb_rdat = rdat_q;

  // ----------------------------------------------------------------------
  // Programmable flags
  // ----------------------------------------------------------------------
  logic [RMX_NFLAG-1:0] flag_lvl;

  // In reset every flag is an input so straps can be read.
  assign prog_flag_oe  = rst_b ? fdir_q : '0;
  assign prog_flag_out = fout_q;
  // An output flag interrupts from its own driven level.
  assign flag_lvl = (fdir_q & fout_q) | (~fdir_q & flag_s);

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  logic [RMX_NFLAG-1:0] lvl_prev_q;
  logic [1:0]           sa_prev_q;
  logic                 spalt;

  assign spalt = ctrl_q[RMX_CTL_SPALT];

  // Requests are active low on the pins.
  assign ev[RMX_IRQ_EL]  = ctrl_q[RMX_CTL_ELEDG] ?
                           (lvl_prev_q[7] && !flag_lvl[7]) : !flag_lvl[7];
  assign ev[RMX_IRQ_L0]  = !flag_lvl[6];
  assign ev[RMX_IRQ_L1]  = !flag_lvl[5];
  assign ev[RMX_IRQ_E]   = lvl_prev_q[4] && !flag_lvl[4];
  assign ev[RMX_IRQ_SA0] = spalt && (ctrl_q[RMX_CTL_SA0ED] ?
                           (sa_prev_q[0] && !rfs_s) : !rfs_s);
  assign ev[RMX_IRQ_SA1] = spalt && (ctrl_q[RMX_CTL_SA1ED] ?
                           (sa_prev_q[1] && !tfs_s) : !tfs_s);

  // A new event beats a clear in the same cycle.
  assign stat_d = (stat_q & ~w1c) | ev;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stat_q     <= '0;
      lvl_prev_q <= '1;
      sa_prev_q  <= 2'b11;
    end else begin
      stat_q     <= stat_d;
      lvl_prev_q <= flag_lvl;
      sa_prev_q  <= {tfs_s, rfs_s};
    end
  end
  assign irq_vector = stat_q & mask_q;
  assign irq_out    = |irq_vector;

  // ----------------------------------------------------------------------
  // Second serial port pins
  // ----------------------------------------------------------------------
  assign sp_rfs_out   = sport_rfs_out;
  assign sp_rfs_oe    = !spalt && sport_rfs_oe;
  assign sp_tfs_out   = sport_tfs_out;
  assign sp_tfs_oe    = !spalt && sport_tfs_oe;
  assign sp_dt_out    = spalt ? ctrl_q[RMX_CTL_FO] : sport_dt_out;
  assign sp_dt_oe     = spalt || sport_dt_oe;
  assign sport_rfs_in = rfs_s;
  assign sport_tfs_in = tfs_s;
  assign sport_dr_in  = dr_s;

  // ----------------------------------------------------------------------
  // Bus request and grant
  // ----------------------------------------------------------------------
  rmx_bus_st_t bus_q;
  rmx_bus_st_t bus_d;
  logic        own;

  always_comb begin
    bus_d = bus_q;
    unique case (bus_q)
      RMX_BUS_OWN:   if (!breq_b_s && !mem_req) bus_d = RMX_BUS_GRANT;
      RMX_BUS_GRANT: if (breq_b_s) bus_d = RMX_BUS_OWN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus_q <= RMX_BUS_OWN;
    end else begin
      bus_q <= bus_d;
    end
  end

  assign own                  = (bus_q == RMX_BUS_OWN);
  assign bus_grant_out_b      = own;
  assign bus_grant_hung_out_b = !(!own && mem_req);
  assign core_halt            = !own && !ctrl_q[RMX_CTL_GO];

  // ----------------------------------------------------------------------
  // External memory pins
  // ----------------------------------------------------------------------
  logic              acc_on;
  logic              is_byte;
  logic              wr_on;
  logic              ack_drive;
  logic [RMX_DW-1:0] full_dout;
  logic [RMX_DW-1:0] full_doe;
  logic [RMX_DW-1:0] host_dout;
  logic [RMX_DW-1:0] host_doe;
  logic [RMX_DW-1:0] rdata_q;

  assign acc_on  = own && mem_req;
  assign wr_on   = acc_on && mem_we;
  assign is_byte = (mem_space == RMX_SP_BYTE);

  assign mem_ctl_oe = own;
  assign mem_rd_b   = !(acc_on && !mem_we);
  assign mem_wr_b   = !wr_on;
  // Order: combined, program, data, byte, io.
  assign mem_sel_b  = ~{acc_on && (mem_space == RMX_SP_IO),
                        acc_on && is_byte,
                        acc_on && (mem_space == RMX_SP_DM),
                        acc_on && (mem_space == RMX_SP_PM),
                        acc_on};

  // Full memory mode: whole buses.
  assign full_dout = is_byte ? {byte_addr_hi, mem_wdata[15:0]} : mem_wdata;
  assign full_doe  = wr_on ? '1 :
                     ((acc_on && is_byte) ? {8'hFF, 16'h0000} : '0);

  // Host ack is open source: it only drives high.
  assign ack_drive = ack_cfg ? host_ack_done : host_ack_ready;
  assign host_dout = {mem_wdata[15:0], 4'h0, 1'b1, host_ad_out[15:13]};
  assign host_doe  = {{16{wr_on}}, 4'h0, ack_drive, {3{host_ad_drive}}};

  assign a_pin_out = host_mode ? {host_ad_out[12:0], mem_addr[0]} : mem_addr;
  assign a_pin_oe  = host_mode ? {{13{host_ad_drive}}, own} : {RMX_AW{own}};
  assign d_pin_out = host_mode ? host_dout : full_dout;
  assign d_pin_oe  = host_mode ? host_doe : full_doe;

  assign host_ad_in          = {d_s[2:0], a_s[13:1]};
  assign host_write_enable_b = d_s[7];
  assign host_read_enable_b  = d_s[6];
  assign host_address_latch  = d_s[5];
  assign host_port_select_b  = d_s[4];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= '0;
    end else if (acc_on && !mem_we) begin
      rdata_q <= host_mode ? {8'h00, d_s[23:8]} : d_s;
    end
  end
  assign mem_rdata = rdata_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_strap_flag_in: assert property (disable iff (1'b0)
    !rst_b |-> prog_flag_oe == '0) else $error("flag driven in reset");
  a_mode_held: assert property (rst_b && $past(rst_b) |->
    $stable(strap_q) && host_mode == strap_q[RMX_STRAP_C])
    else $error("mode changed");
  a_full_addr_bus: assert property (!host_mode && acc_on |->
    a_pin_oe == '1 && a_pin_out == mem_addr) else $error("full address bad");
  a_byte_addr_hi: assert property (!host_mode && acc_on && is_byte |->
    d_pin_out[23:16] == byte_addr_hi && d_pin_oe[23:16] == 8'hFF)
    else $error("byte addr bad");
  a_host_ad_pins: assert property (host_mode |->
    a_pin_oe[13:1] == {13{host_ad_drive}} && d_pin_oe[7:4] == 4'h0)
    else $error("host bus pins bad");
  a_host_ack_src: assert property (host_mode |-> d_pin_out[3] &&
    d_pin_oe[3] == (ack_cfg ? host_ack_done : host_ack_ready))
    else $error("ack drive bad");
  a_flag_self_irq: assert property (fdir_q[6] && !fout_q[6] |=>
    stat_q[RMX_IRQ_L0]) else $error("flag irq lost");
  a_edge_only_irq: assert property ($fell(flag_lvl[4]) |=>
    stat_q[RMX_IRQ_E]) else $error("edge irq lost");
  a_alt_flag_out: assert property (spalt |-> sp_dt_oe &&
    sp_dt_out == ctrl_q[RMX_CTL_FO] && !sp_rfs_oe) else $error("alt pins bad");
  a_grant_halt: assert property (!own ##1 !own |->
    core_halt == !ctrl_q[RMX_CTL_GO] && !a_pin_oe[0])
    else $error("grant halt bad");

  c_host_mode: cover property (host_mode && host_ad_drive);
  c_bus_grant: cover property (own ##1 !own ##[1:8] own);
  c_alt_irq:   cover property (spalt && ev[RMX_IRQ_SA0] ##1 irq_out);
  c_clear_set: cover property (|(w1c & ev));

endmodule

// ==== tb/rmx_far_end.sv ====
// Far side model: external memory in full mode, host in host mode.
// Takes the device's out/oe pairs and returns resolved levels.
`timescale 1ns/1ns
module rmx_far_end
  import rmx_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [RMX_AW-1:0] a_out,
  input  wire logic [RMX_AW-1:0] a_oe,
  input  wire logic [RMX_DW-1:0] d_out,
  input  wire logic [RMX_DW-1:0] d_oe,
  input  wire logic              rd_b,
  input  wire logic              ctl_oe,
  input  wire logic              hmode,
  input  wire logic              host_drv,
  input  wire logic [RMX_HW-1:0] host_ad,
  input  wire logic [3:0]        host_ctl,
  output logic      [RMX_AW-1:0] a_in,
  output logic      [RMX_DW-1:0] d_in
);
  logic [RMX_DW-1:0] last_d = '0;
  logic [RMX_AW-1:0] last_a = '0;
  logic [RMX_DW-1:0] word;
  logic [RMX_DW-1:0] drv_d;
  logic [RMX_DW-1:0] ext_d;
  logic [RMX_AW-1:0] drv_a;
  wire               rd = ~rd_b & ctl_oe;
  // In host mode peripherals decode on one address pin.
  assign word = hmode ? {(a_out[0] ? 16'h5AA5 : 16'hA55A), 8'h00} : {~a_out[9:0], a_out};
  assign drv_d = (rd ? {16'hFFFF, {8{~hmode}}} : '0)
               | (hmode ? {16'h0000, 5'h1F, {3{host_drv}}} : '0);
  // The ack line has a pull-down.
  assign ext_d = {word[23:8], hmode ? {host_ctl, 1'b0, host_ad[15:13]} : word[7:0]};
  assign drv_a = (hmode & host_drv) ? 14'h3FFE : '0;
  // A released line shows the inverse of its last level.
  assign d_in = (d_oe & d_out) | (~d_oe & drv_d & ext_d) | (~d_oe & ~drv_d & ~last_d);
  assign a_in = (a_oe & a_out) | (~a_oe & drv_a & {host_ad[12:0], 1'b0})
              | (~a_oe & ~drv_a & ~last_a);
  always_ff @(posedge clk) begin
    last_d <= d_in;
    last_a <= a_in;
  end
endmodule

// ==== tb/rmx_pin_mux_tb.sv ====
// Self-checking bench of the strap pin multiplexer.
// Assumes the far-end model resolves the pins.
`timescale 1ns/1ns
module rmx_pin_mux_tb;
  import rmx_pkg::*;
  logic        clk = 0, rst_b = 0, wb_we = 0, wb_cyc = 0, wb_stb = 0, wb_ack, irq_out;
  logic [7:0]  wb_adr = '0, pf_out, pf_oe, fl_drv = 8'hFF, byte_addr_hi = '0;
  logic [31:0] wb_wdat = '0, wb_rdat, r;
  logic [3:0]  wb_sel = 4'hF, h_ctl = 4'hD;
  logic [5:0]  irq_vector, sp_v = '0;
  logic [13:0] a_pin_in, a_pin_out, a_pin_oe, mem_addr = '0;
  logic [23:0] d_pin_in, d_pin_out, d_pin_oe, mem_wdata = '0, mem_rdata;
  logic [4:0]  mem_sel_b;
  logic [1:0]  mem_space = '0;
  logic [15:0] host_ad_out = '0, host_ad_in, h_ad = '0;
  logic        mem_rd_b, mem_wr_b, mem_ctl_oe, bus_grant_out_b, bus_grant_hung_out_b;
  logic        bus_request_in_b = 1, mem_req = 0, mem_we = 0, core_halt, host_mode;
  logic        host_ad_drive = 0, host_ack_ready = 0, host_ack_done = 0, h_drv = 0;
  logic        host_write_enable_b, host_read_enable_b, host_address_latch, host_port_select_b;
  logic        sp_rfs_in = 1, sp_tfs_in = 1, sp_dr_in = 1, sp_rfs_out, sp_rfs_oe;
  logic        sp_tfs_out, sp_tfs_oe, sp_dt_out, sp_dt_oe, sport_rfs_in, sport_tfs_in, sport_dr_in;
  wire  [7:0]  pf_in = (pf_oe & pf_out) | (~pf_oe & fl_drv);
  int          bad_count = 0, n_tests = 0;

  rmx_pin_mux i_rmx_pin_mux (.clk, .rst_b, .wb_adr, .wb_wdat, .wb_sel, .wb_we, .wb_cyc,
    .wb_stb, .wb_rdat, .wb_ack, .irq_out, .irq_vector, .prog_flag_in(pf_in),
    .prog_flag_out(pf_out), .prog_flag_oe(pf_oe), .a_pin_in, .a_pin_out, .a_pin_oe,
    .d_pin_in, .d_pin_out, .d_pin_oe, .mem_sel_b, .mem_rd_b, .mem_wr_b, .mem_ctl_oe,
    .bus_request_in_b, .bus_grant_out_b, .bus_grant_hung_out_b, .mem_req, .mem_we,
    .mem_space, .mem_addr, .mem_wdata, .byte_addr_hi, .mem_rdata, .core_halt, .host_mode,
    .host_ad_out, .host_ad_drive, .host_ack_ready, .host_ack_done, .host_ad_in,
    .host_write_enable_b, .host_read_enable_b, .host_address_latch, .host_port_select_b,
    .sp_rfs_in, .sp_rfs_out, .sp_rfs_oe, .sp_tfs_in, .sp_tfs_out, .sp_tfs_oe, .sp_dr_in,
    .sp_dt_out, .sp_dt_oe, .sport_rfs_out(sp_v[5]), .sport_rfs_oe(sp_v[4]),
    .sport_tfs_out(sp_v[3]), .sport_tfs_oe(sp_v[2]), .sport_dt_out(sp_v[1]),
    .sport_dt_oe(sp_v[0]), .sport_rfs_in, .sport_tfs_in, .sport_dr_in);

  rmx_far_end i_rmx_far_end (.clk, .a_out(a_pin_out), .a_oe(a_pin_oe), .d_out(d_pin_out),
    .d_oe(d_pin_oe), .rd_b(mem_rd_b), .ctl_oe(mem_ctl_oe), .hmode(host_mode),
    .host_drv(h_drv), .host_ad(h_ad), .host_ctl(h_ctl), .a_in(a_pin_in), .d_in(d_pin_in));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  initial forever #5 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // The request stands until ack is seen, for at most 20 cycles.
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    wb_adr <= a;
    wb_we <= we;
    wb_wdat <= d;
    wb_cyc <= 1;
    wb_stb <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    r = wb_rdat;
    chk(n < 20, 1);
    wb_cyc <= 0;
    wb_stb <= 0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 0, 0);
    chk(r, exp);
  endtask

  task automatic do_reset(input logic [3:0] strap);
    rst_b <= 0;
    fl_drv <= {4'hF, strap};
    repeat (12) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
  endtask

  task automatic irq_try(input int p, input int b, input logic stay);
    fl_drv[p] <= 0;
    repeat (6) @(posedge clk);
    wb(RMX_OFF_ISTAT, 0, 0);
    chk(r[b], 1);
    chk(irq_vector[b], 1);
    wb(RMX_OFF_ISTAT, 1, 32'h0000_0001 << b);
    wb(RMX_OFF_ISTAT, 0, 0);
    chk(r[b], stay);
    fl_drv[p] <= 1;
    repeat (6) @(posedge clk);
    wb(RMX_OFF_ISTAT, 1, 32'h0000_003F);
    @(posedge clk);
    chk(irq_out, 0);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rd(RMX_OFF_MODE, 32'h0000_000A);
    fl_drv <= 8'hF5;
    repeat (4) @(posedge clk);
    wb(RMX_OFF_MODE, 1, 32'h0000_001F);
    rd(RMX_OFF_MODE, 32'h0000_000A);
    chk(host_mode, 0);
    rd(RMX_OFF_FDIR, RMX_FDIR_RST);
    rd(RMX_OFF_FOUT, RMX_FOUT_RST);
    rd(RMX_OFF_CTRL, RMX_CTRL_RST);
    rd(RMX_OFF_INTERRUPT_MASK, RMX_INTERRUPT_MASK_RST);
    rd(8'h1C, 0);
  endtask

  task automatic t_flags();
    wb(RMX_OFF_FDIR, 1, 32'h0000_000F);
    wb(RMX_OFF_FOUT, 1, 32'h0000_00F6);
    @(posedge clk);
    chk(pf_oe, 8'h0F);
    chk(pf_out, 8'hF6);
    fl_drv <= 8'hA5;
    repeat (4) @(posedge clk);
    wb(RMX_OFF_FIN, 0, 0);
    chk(r[7:0], 8'hA6);
    wb(RMX_OFF_ISTAT, 0, 0);
    chk(r[RMX_IRQ_L0], 1);
    wb(RMX_OFF_FDIR, 1, 0);
    fl_drv <= 8'hFF;
  endtask

  task automatic t_irq();
    repeat (6) @(posedge clk);
    wb(RMX_OFF_INTERRUPT_MASK, 1, 32'h0000_003F);
    wb(RMX_OFF_ISTAT, 1, 32'h0000_003F);
    irq_try(6, RMX_IRQ_L0, 1);
    irq_try(5, RMX_IRQ_L1, 1);
    irq_try(4, RMX_IRQ_E, 0);
    irq_try(7, RMX_IRQ_EL, 1);
    wb(RMX_OFF_CTRL, 1, 32'h0000_0004);
    irq_try(7, RMX_IRQ_EL, 0);
    wb(RMX_OFF_INTERRUPT_MASK, 1, 0);
    wb(RMX_OFF_FDIR, 1, 32'h0000_00C0);
    wb(RMX_OFF_FOUT, 1, 32'h0000_003F);
    repeat (4) @(posedge clk);
    chk(irq_out, 0);
    rd(RMX_OFF_ISTAT, 32'h0000_0003);
    wb(RMX_OFF_INTERRUPT_MASK, 1, 32'h0000_0001);
    @(posedge clk);
    chk(irq_out, 1);
    wb(RMX_OFF_FDIR, 1, 0);
    wb(RMX_OFF_FOUT, 1, 32'h0000_00FF);
    wb(RMX_OFF_CTRL, 1, 0);
    wb(RMX_OFF_ISTAT, 1, 32'h0000_003F);
    wb(RMX_OFF_INTERRUPT_MASK, 1, 32'h0000_003F);
  endtask

  task automatic t_mem();
    logic [4:0] sel_exp [4] = '{5'h1C, 5'h1A, 5'h16, 5'h0E};
    for (int s = 0; s < 4; s++) begin
      mem_req <= 1;
      mem_we <= 1;
      mem_space <= s[1:0];
      mem_addr <= 14'h2A5C;
      mem_wdata <= 24'hC3_5AA5;
      byte_addr_hi <= 8'h9E;
      @(posedge clk);
      chk(a_pin_out, 14'h2A5C);
      chk(a_pin_oe, 14'h3FFF);
      chk(d_pin_oe, 24'hFF_FFFF);
      chk({mem_sel_b, mem_wr_b}, {sel_exp[s], 1'b0});
      if (s == 2) chk(d_pin_out[23:16], 8'h9E);
      else chk(d_pin_out, 24'hC3_5AA5);
    end
    mem_we <= 0;
    mem_space <= RMX_SP_DM;
    repeat (4) @(posedge clk);
    chk({d_pin_oe, mem_rd_b}, 0);
    chk(mem_rdata, {10'h1A3, 14'h2A5C});
    mem_space <= RMX_SP_BYTE;
    @(posedge clk);
    chk(d_pin_oe[23:16], 8'hFF);
    mem_req <= 0;
  endtask

  task automatic t_grant();
    bus_request_in_b <= 0;
    for (int n = 0; n < 8 && bus_grant_out_b !== 1'b0; n++) @(posedge clk);
    chk({bus_grant_out_b, core_halt, mem_ctl_oe}, 3'b010);
    chk(a_pin_oe, 0);
    wb(RMX_OFF_CTRL, 1, 32'h0000_0002);
    mem_req <= 1;
    repeat (2) @(posedge clk);
    chk({core_halt, bus_grant_hung_out_b}, 2'b00);
    mem_req <= 0;
    bus_request_in_b <= 1;
    for (int n = 0; n < 8 && bus_grant_out_b !== 1'b1; n++) @(posedge clk);
    chk(bus_grant_out_b, 1);
    wb(RMX_OFF_CTRL, 1, 0);
  endtask

  task automatic t_serial();
    sp_v <= 6'b110100;
    @(posedge clk);
    chk({sp_rfs_out, sp_rfs_oe, sp_tfs_out, sp_tfs_oe, sp_dt_out, sp_dt_oe}, 6'h34);
    wb(RMX_OFF_CTRL, 1, 32'h0000_0021);
    @(posedge clk);
    chk({sp_rfs_oe, sp_tfs_oe, sp_dt_out, sp_dt_oe}, 4'b0011);
    sp_rfs_in <= 0;
    sp_tfs_in <= 0;
    repeat (6) @(posedge clk);
    wb(RMX_OFF_ISTAT, 0, 0);
    chk(r[5:4], 2'b11);
    chk({sport_rfs_in, sport_tfs_in, sport_dr_in}, 3'b001);
    sp_rfs_in <= 1;
    sp_tfs_in <= 1;
    wb(RMX_OFF_CTRL, 1, 0);
    @(posedge clk);
    chk({sp_rfs_out, sp_rfs_oe, sp_tfs_out, sp_tfs_oe, sp_dt_out, sp_dt_oe}, 6'h34);
  endtask

  task automatic t_host();
    do_reset(4'h4);
    rd(RMX_OFF_MODE, 32'h0000_0014);
    h_drv <= 1;
    h_ad <= 16'hBEEF;
    h_ctl <= 4'b0110;
    repeat (4) @(posedge clk);
    chk(host_ad_in, 16'hBEEF);
    chk({host_write_enable_b, host_read_enable_b, host_address_latch,
         host_port_select_b}, 4'b0110);
    h_drv <= 0;
    host_ad_out <= 16'h1234;
    host_ad_drive <= 1;
    @(posedge clk);
    chk({d_pin_out[2:0], a_pin_out[13:1]}, 16'h1234);
    chk({d_pin_oe[2:0], a_pin_oe[13:1]}, 16'hFFFF);
    host_ad_drive <= 0;
    host_ack_ready <= 1;
    @(posedge clk);
    chk({d_pin_oe[3], d_pin_out[3]}, 2'b11);
    host_ack_ready <= 0;
    host_ack_done <= 1;
    @(posedge clk);
    chk(d_pin_oe[3], 0);
    mem_req <= 1;
    mem_we <= 1;
    mem_space <= RMX_SP_IO;
    mem_addr <= 14'h0001;
    @(posedge clk);
    chk({a_pin_oe, d_pin_oe}, {14'h0001, 24'hFF_FF00});
    mem_we <= 0;
    repeat (4) @(posedge clk);
    chk(mem_rdata, 24'h00_5AA5);
    mem_req <= 0;
  endtask

  initial begin
    do_reset(4'hA);
    t_regs();
    t_flags();
    t_irq();
    t_mem();
    t_grant();
    t_serial();
    t_host();
    close_out();
  end

  // A run takes a few hundred cycles.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule
